// ---- core/address_io_ports_b_c.v ----
// What this block does
// - Each port has an 8-bit read/write output data register, cleared by resets.
// - Each port has a read-only pin-state register; writes to it are ignored.
// - Pin-state read gives data bit where direction is 1, pin level otherwise.
// - After reset pin-state shows pins; it holds during software standby.
// - Port B has an 8-bit read/write pull-up control register, cleared by resets.
// - Pull-up on only in modes 6 and 7 for input pins with control set.
// - Pull-up off in reset, hardware standby and modes 4, 5; kept in software standby.
// - Modes 4 and 5 make every pin an address output.
// - Mode 6: direction 1 drives address bit, direction 0 is input.
// - Mode 7: direction 1 drives data bit, direction 0 is input.
// - Port C direction is 8-bit write-only; reads undefined; cleared by resets.
// - In software standby address pins keep state or float per keep bit.
// - Port C registers decode at FEBB, FF6B, FF5B and FF72.
// - Port B direction is 8-bit write-only; reads undefined; cleared by resets.
// - Port C has per-pin pull-up control, same enabling as port B.
// - Port C pin-state read follows direction the same way as port B.
// - Port B registers decode at FEBA, FF6A, FF5A and FF71.
`timescale 1ns/1ps
`default_nettype none
`include "address_io_ports_defines.vh"

module address_io_ports_b_c (
  // Clock and reset
  input wire clk_in,
  input wire rst_b_in,
  // Wishbone classic slave
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [17:0] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out,
  // Mode and standby
  input wire [2:0] mode_in,
  input wire hw_standby_in,
  input wire sw_standby_in,
  input wire standby_output_keep_in,
  // Internal address bus
  input wire [15:0] address_in,
  // Port B pins
  input wire [7:0] port_b_pin_in,
  output wire [7:0] port_b_pin_out,
  output wire [7:0] port_b_oe_out,
  output wire [7:0] port_b_pullup_out,
  // Port C pins
  input wire [7:0] port_c_pin_in,
  output wire [7:0] port_c_pin_out,
  output wire [7:0] port_c_oe_out,
  output wire [7:0] port_c_pullup_out
);

  // ----------------------------------------
  // Mode and hardware standby synchronisers
  // ----------------------------------------
  reg [2:0] mode_meta_q;
  reg [2:0] mode_q;
  reg hw_meta_q;
  reg hw_standby_q;

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      mode_meta_q <= 3'h0;
      mode_q <= 3'h0;
    end else begin
      mode_meta_q <= mode_in;
      mode_q <= mode_meta_q;
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      hw_meta_q <= 1'b0;
      hw_standby_q <= 1'b0;
    end else begin
      hw_meta_q <= hw_standby_in;
      hw_standby_q <= hw_meta_q;
    end
  end

  wire addr_all;
  wire mode_mixed;
  wire mode_gpio;

  // Modes 0 to 3 leave every pin an input
  assign addr_all = (mode_q == `MODE_ADDR_4) || (mode_q == `MODE_ADDR_5);
  assign mode_mixed = (mode_q == `MODE_MIXED_6);
  assign mode_gpio = (mode_q == `MODE_GPIO_7);

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  wire [15:0] reg_idx;
  wire bus_req;
  wire bus_take;
  wire rd_take;
  wire wr_go;
  wire lane0;

  assign reg_idx = wb_adr_in[`WB_IDX_MSB:`WB_IDX_LSB];
  assign bus_req = wb_cyc_in & wb_stb_in;
  // Request taken on the edge where ack is still low
  assign bus_take = bus_req & ~wb_ack_out;
  assign rd_take = bus_take & ~wb_we_in;
  // Write lands on the edge that the master samples ack
  assign wr_go = bus_req & wb_ack_out & wb_we_in;
  assign lane0 = wb_sel_in[0];

  wire hit_b_dir;
  wire hit_c_dir;
  wire hit_b_data;
  wire hit_c_data;
  wire hit_b_pcr;
  wire hit_c_pcr;

  assign hit_b_dir = (reg_idx == `PORT_B_DIRECTION_IDX);
  assign hit_c_dir = (reg_idx == `PORT_C_DIRECTION_IDX);
  assign hit_b_data = (reg_idx == `PORT_B_OUTPUT_DATA_IDX);
  assign hit_c_data = (reg_idx == `PORT_C_OUTPUT_DATA_IDX);
  assign hit_b_pcr = (reg_idx == `PORT_B_PULLUP_CONTROL_IDX);
  assign hit_c_pcr = (reg_idx == `PORT_C_PULLUP_CONTROL_IDX);

  // ----------------------------------------
  // Port registers
  // ----------------------------------------
  reg [7:0] port_b_direction_q;
  reg [7:0] port_c_direction_q;
  reg [7:0] port_b_output_data_q;
  reg [7:0] port_c_output_data_q;
  reg [7:0] port_b_pullup_control_q;
  reg [7:0] port_c_pullup_control_q;
  wire wr_lane;
  wire wr_b_dir;
  wire wr_c_dir;
  wire wr_b_data;
  wire wr_c_data;
  wire wr_b_pcr;
  wire wr_c_pcr;

  // Pin-state indices have no strobe, so writes there are lost
  assign wr_lane = wr_go & lane0;
  assign wr_b_dir = wr_lane & hit_b_dir;
  assign wr_c_dir = wr_lane & hit_c_dir;
  assign wr_b_data = wr_lane & hit_b_data;
  assign wr_c_data = wr_lane & hit_c_data;
  assign wr_b_pcr = wr_lane & hit_b_pcr;
  assign wr_c_pcr = wr_lane & hit_c_pcr;

  // Hardware standby clears like reset; software standby needs nothing
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port_b_direction_q <= `PORT_REG_RESET;
    end else if (hw_standby_q) begin
      port_b_direction_q <= `PORT_REG_RESET;
    end else if (wr_b_dir) begin
      port_b_direction_q <= wb_dat_in[7:0];
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port_c_direction_q <= `PORT_REG_RESET;
    end else if (hw_standby_q) begin
      port_c_direction_q <= `PORT_REG_RESET;
    end else if (wr_c_dir) begin
      port_c_direction_q <= wb_dat_in[7:0];
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port_b_output_data_q <= `PORT_REG_RESET;
    end else if (hw_standby_q) begin
      port_b_output_data_q <= `PORT_REG_RESET;
    end else if (wr_b_data) begin
      port_b_output_data_q <= wb_dat_in[7:0];
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port_c_output_data_q <= `PORT_REG_RESET;
    end else if (hw_standby_q) begin
      port_c_output_data_q <= `PORT_REG_RESET;
    end else if (wr_c_data) begin
      port_c_output_data_q <= wb_dat_in[7:0];
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port_b_pullup_control_q <= `PORT_REG_RESET;
    end else if (hw_standby_q) begin
      port_b_pullup_control_q <= `PORT_REG_RESET;
    end else if (wr_b_pcr) begin
      port_b_pullup_control_q <= wb_dat_in[7:0];
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      port_c_pullup_control_q <= `PORT_REG_RESET;
    end else if (hw_standby_q) begin
      port_c_pullup_control_q <= `PORT_REG_RESET;
    end else if (wr_c_pcr) begin
      port_c_pullup_control_q <= wb_dat_in[7:0];
    end
  end

  // ----------------------------------------
  // Pin logic, one slice per port
  // ----------------------------------------
  wire [7:0] port_b_pin_state;
  wire [7:0] port_c_pin_state;

  // Slices share mode and standby; registers and address byte differ
  port_pin_slice port_b_slice (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .addr_all_in(addr_all),
    .mode_mixed_in(mode_mixed),
    .mode_gpio_in(mode_gpio),
    .hw_standby_in(hw_standby_q),
    .sw_standby_in(sw_standby_in),
    .standby_output_keep_in(standby_output_keep_in),
    .direction_in(port_b_direction_q),
    .output_data_in(port_b_output_data_q),
    .pullup_control_in(port_b_pullup_control_q),
    .address_in(address_in[15:8]),
    .pin_in(port_b_pin_in),
    .pin_out(port_b_pin_out),
    .pin_oe_out(port_b_oe_out),
    .pullup_en_out(port_b_pullup_out),
    .pin_state_out(port_b_pin_state)
  );

  port_pin_slice port_c_slice (
    .clk_in(clk_in),
    .rst_b_in(rst_b_in),
    .addr_all_in(addr_all),
    .mode_mixed_in(mode_mixed),
    .mode_gpio_in(mode_gpio),
    .hw_standby_in(hw_standby_q),
    .sw_standby_in(sw_standby_in),
    .standby_output_keep_in(standby_output_keep_in),
    .direction_in(port_c_direction_q),
    .output_data_in(port_c_output_data_q),
    .pullup_control_in(port_c_pullup_control_q),
    .address_in(address_in[7:0]),
    .pin_in(port_c_pin_in),
    .pin_out(port_c_pin_out),
    .pin_oe_out(port_c_oe_out),
    .pullup_en_out(port_c_pullup_out),
    .pin_state_out(port_c_pin_state)
  );

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  reg [7:0] rd_byte;

  always @* begin
    case (reg_idx)
      `PORT_B_OUTPUT_DATA_IDX: rd_byte = port_b_output_data_q;
      `PORT_C_OUTPUT_DATA_IDX: rd_byte = port_c_output_data_q;
      `PORT_B_PIN_STATE_IDX: rd_byte = port_b_pin_state;
      `PORT_C_PIN_STATE_IDX: rd_byte = port_c_pin_state;
      `PORT_B_PULLUP_CONTROL_IDX: rd_byte = port_b_pullup_control_q;
      `PORT_C_PULLUP_CONTROL_IDX: rd_byte = port_c_pullup_control_q;
      // Direction registers cannot be read back
      `PORT_B_DIRECTION_IDX: rd_byte = `UNDEF_READ;
      `PORT_C_DIRECTION_IDX: rd_byte = `UNDEF_READ;
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------------------------------------
  // Bus answer, one wait cycle
  // ----------------------------------------
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= bus_take;
    end
  end

  // Read data stands only in the ack cycle, zero otherwise
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wb_dat_out <= 32'h00000000;
    end else if (rd_take) begin
      wb_dat_out <= {24'h000000, rd_byte};
    end else begin
      wb_dat_out <= 32'h00000000;
    end
  end

endmodule
`default_nettype wire

// ---- core/address_io_ports_defines.vh ----
`ifndef ADDRESS_IO_PORTS_DEFINES_VH
`define ADDRESS_IO_PORTS_DEFINES_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define PORT_B_DIRECTION_IDX 16'hFEBA
`define PORT_C_DIRECTION_IDX 16'hFEBB
`define PORT_B_PIN_STATE_IDX 16'hFF5A
`define PORT_C_PIN_STATE_IDX 16'hFF5B
`define PORT_B_OUTPUT_DATA_IDX 16'hFF6A
`define PORT_C_OUTPUT_DATA_IDX 16'hFF6B
`define PORT_B_PULLUP_CONTROL_IDX 16'hFF71
`define PORT_C_PULLUP_CONTROL_IDX 16'hFF72

// ----------------------------------------
// Reset values and field layout
// ----------------------------------------
`define PORT_REG_RESET 8'h00
`define PORT_WIDTH 8
`define WB_IDX_LSB 2
`define WB_IDX_MSB 17
`define WB_ADR_WIDTH 18
`define WB_DATA_WIDTH 32
`define UNDEF_READ 8'h00

// ----------------------------------------
// Operating mode codes
// ----------------------------------------
`define MODE_WIDTH 3
`define MODE_ADDR_4 3'h4
`define MODE_ADDR_5 3'h5
`define MODE_MIXED_6 3'h6
`define MODE_GPIO_7 3'h7

`endif

// ---- core/port_pin_slice.v ----
`timescale 1ns/1ps
`default_nettype none
`include "address_io_ports_defines.vh"

module port_pin_slice (
  // Clock and reset
  input wire clk_in,
  input wire rst_b_in,
  // Mode and standby controls, same clock domain
  input wire addr_all_in,
  input wire mode_mixed_in,
  input wire mode_gpio_in,
  input wire hw_standby_in,
  input wire sw_standby_in,
  input wire standby_output_keep_in,
  // Port registers and address byte
  input wire [7:0] direction_in,
  input wire [7:0] output_data_in,
  input wire [7:0] pullup_control_in,
  input wire [7:0] address_in,
  // Pins
  input wire [7:0] pin_in,
  output reg [7:0] pin_out,
  output reg [7:0] pin_oe_out,
  output reg [7:0] pullup_en_out,
  // Pin-state register
  output reg [7:0] pin_state_out
);

  // ----------------------------------------
  // Pin synchroniser
  // ----------------------------------------
  reg [7:0] pin_meta_q;
  reg [7:0] pin_sync_q;

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_meta_q <= `PORT_REG_RESET;
      pin_sync_q <= `PORT_REG_RESET;
    end else begin
      pin_meta_q <= pin_in;
      pin_sync_q <= pin_meta_q;
    end
  end

  // ----------------------------------------
  // Pin function per bit
  // ----------------------------------------
  wire [7:0] drive_addr;
  wire [7:0] drive_gpio;
  reg [7:0] out_d;
  reg [7:0] oe_d;
  reg [7:0] pullup_d;
  reg [7:0] state_d;

  assign drive_addr = {8{addr_all_in}} | ({8{mode_mixed_in}} & direction_in);
  assign drive_gpio = {8{mode_gpio_in}} & direction_in;

  always @* begin
    // Address pins freeze on software standby
    out_d = (drive_addr & (sw_standby_in ? pin_out : address_in)) |
            (~drive_addr & output_data_in);
    if (hw_standby_in) begin
      oe_d = 8'h00;
    end else if (sw_standby_in && !standby_output_keep_in) begin
      oe_d = drive_gpio;
    end else begin
      oe_d = drive_addr | drive_gpio;
    end
    // Pull-up only for inputs in modes 6 and 7
    pullup_d = {8{(mode_mixed_in | mode_gpio_in) & ~hw_standby_in}} &
               ~direction_in & pullup_control_in;
    // Pin-state holds during software standby
    if (sw_standby_in) begin
      state_d = pin_state_out;
    end else begin
      state_d = (direction_in & output_data_in) | (~direction_in & pin_sync_q);
    end
  end

  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      pin_out <= `PORT_REG_RESET;
      pin_oe_out <= `PORT_REG_RESET;
      pullup_en_out <= `PORT_REG_RESET;
      pin_state_out <= `PORT_REG_RESET;
    end else begin
      pin_out <= out_d;
      pin_oe_out <= oe_d;
      pullup_en_out <= pullup_d;
      pin_state_out <= state_d;
    end
  end

endmodule
`default_nettype wire

// ---- dv/address_io_ports_b_c_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
module ports_monitor (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Bus
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  // Mode and standby
  input wire logic [2:0] mode_in,
  input wire logic hw_standby_in,
  input wire logic sw_standby_in,
  input wire logic standby_output_keep_in,
  input wire logic [15:0] address_in,
  // Pins
  input wire logic [7:0] port_b_pin_out,
  input wire logic [7:0] port_b_oe_out,
  input wire logic [7:0] port_b_pullup_out,
  input wire logic [7:0] port_c_pin_out,
  input wire logic [7:0] port_c_oe_out,
  input wire logic [7:0] port_c_pullup_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  wire m45 = mode_in[2:1] == 2'b10;
  wire run45 = m45 && !hw_standby_in && !sw_standby_in;
  wire sb45 = m45 && sw_standby_in && !hw_standby_in;
  ack_after_take_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("no ack after request");
  ack_single_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  ack_cause_a: assert property ($rose(wb_ack_out) |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  read_data_a: assert property (wb_dat_out[31:8] == 24'h0 && (wb_ack_out || wb_dat_out == 32'h0))
    else $error("read data outside ack or wide");
  addr_out_a: assert property (run45[*5] |->
    port_b_oe_out == 8'hFF && port_c_oe_out == 8'hFF &&
    port_b_pin_out == $past(address_in[15:8]) && port_c_pin_out == $past(address_in[7:0]))
    else $error("address pins wrong");
  pullup_off45_a: assert property (m45[*5] |->
    (port_b_pullup_out | port_c_pullup_out) == 8'h00)
    else $error("pull-up on in address mode");
  hw_float_a: assert property (hw_standby_in[*5] |->
    (port_b_oe_out | port_c_oe_out | port_b_pullup_out | port_c_pullup_out) == 8'h00)
    else $error("drive or pull-up in hardware standby");
  standby_float_a: assert property ((sb45 && !standby_output_keep_in)[*5] |->
    (port_b_oe_out | port_c_oe_out) == 8'h00)
    else $error("address pins driven in standby");
  standby_keep_a: assert property ((sb45 && standby_output_keep_in)[*5] |->
    (port_b_oe_out & port_c_oe_out) == 8'hFF)
    else $error("address pins released in standby");
  pull_drive_excl_a: assert property (
    ((port_b_pullup_out & port_b_oe_out) | (port_c_pullup_out & port_c_oe_out)) == 8'h00)
    else $error("pull-up on a driven pin");
  cover property (run45[*5]);
  cover property (sb45 && standby_output_keep_in);
  cover property (port_b_pullup_out != 8'h00);
endmodule
bind address_io_ports_b_c ports_monitor u_mon (.clk_in, .rst_b_in, .wb_cyc_in, .wb_stb_in,
  .wb_dat_out, .wb_ack_out, .mode_in, .hw_standby_in, .sw_standby_in, .standby_output_keep_in,
  .address_in, .port_b_pin_out, .port_b_oe_out, .port_b_pullup_out, .port_c_pin_out,
  .port_c_oe_out, .port_c_pullup_out);
`default_nettype wire

// ---- dv/pin_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
  // Board side of one port
  input wire logic clk_in,
  input wire logic [7:0] pin_out_in,
  input wire logic [7:0] oe_in,
  input wire logic [7:0] pullup_in,
  input wire logic [7:0] drive_in,
  input wire logic [7:0] drive_en_in,
  output logic [7:0] level_out
);
  logic [7:0] float_q = 8'h55;
  // Undriven pins without pull-up wander
  always @(posedge clk_in) float_q <= ~float_q;
  assign level_out = (oe_in & pin_out_in) | (~oe_in & drive_en_in & drive_in)
    | (~oe_in & ~drive_en_in & (pullup_in | float_q));
endmodule
`default_nettype wire

// ---- dv/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "address_io_ports_defines.vh"
module tb;
  logic clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, hw = 1'b0, sw = 1'b0, keep = 1'b0, ack;
  logic [17:0] adr = 18'h0;
  logic [3:0] sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic [2:0] mode = 3'h7;
  logic [15:0] addr = 16'h1234;
  logic [7:0] b_in, b_out, b_oe, b_pu, c_in, c_out, c_oe, c_pu, v;
  logic [7:0] ext_b = 8'h5A, ext_c = 8'hC3, en = 8'hFF;
  int err_total = 0, checks_done = 0;
  always #5 clk_in = ~clk_in;
  address_io_ports_b_c DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .mode_in(mode), .hw_standby_in(hw),
    .sw_standby_in(sw), .standby_output_keep_in(keep), .address_in(addr),
    .port_b_pin_in(b_in), .port_b_pin_out(b_out), .port_b_oe_out(b_oe),
    .port_b_pullup_out(b_pu), .port_c_pin_in(c_in), .port_c_pin_out(c_out),
    .port_c_oe_out(c_oe), .port_c_pullup_out(c_pu));
  pin_partner u_pb (.clk_in(clk_in), .pin_out_in(b_out), .oe_in(b_oe), .pullup_in(b_pu),
    .drive_in(ext_b), .drive_en_in(en), .level_out(b_in));
  pin_partner u_pc (.clk_in(clk_in), .pin_out_in(c_out), .oe_in(c_oe), .pullup_in(c_pu),
    .drive_in(ext_c), .drive_en_in(en), .level_out(c_in));
  task results;
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // One classic cycle, held until ack
  task acc(input logic w, input logic [15:0] idx, input logic [7:0] d);
    int n;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    wdat <= {24'h0, d};
    sel <= 4'h1;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (ack !== 1'b1 && n < 40);
    v = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
    if (n >= 40) begin
      err_total++;
      results;
    end
  endtask
  task rd(input string nm, input logic [15:0] idx, input logic [7:0] e);
    acc(1'b0, idx, 8'h00);
    chk(nm, v, e);
  endtask
  initial begin
    tick(20);
    rst_b_in <= 1'b1;
    tick(4);
    rd("b_data", `PORT_B_OUTPUT_DATA_IDX, 8'h00);
    rd("c_data", `PORT_C_OUTPUT_DATA_IDX, 8'h00);
    rd("b_pull", `PORT_B_PULLUP_CONTROL_IDX, 8'h00);
    rd("c_pull", `PORT_C_PULLUP_CONTROL_IDX, 8'h00);
    rd("b_state", `PORT_B_PIN_STATE_IDX, 8'h5A);
    rd("c_state", `PORT_C_PIN_STATE_IDX, 8'hC3);
    acc(1'b1, `PORT_B_DIRECTION_IDX, 8'hF0);
    acc(1'b1, `PORT_B_OUTPUT_DATA_IDX, 8'hA5);
    acc(1'b1, `PORT_C_DIRECTION_IDX, 8'h0F);
    acc(1'b1, `PORT_C_OUTPUT_DATA_IDX, 8'h96);
    acc(1'b1, `PORT_B_PIN_STATE_IDX, 8'hFF);
    tick(6);
    rd("b_state", `PORT_B_PIN_STATE_IDX, 8'hAA);
    rd("c_state", `PORT_C_PIN_STATE_IDX, 8'hC6);
    rd("b_data", `PORT_B_OUTPUT_DATA_IDX, 8'hA5);
    rd("c_dir", `PORT_C_DIRECTION_IDX, `UNDEF_READ);
    chk("b_oe", b_oe, 8'hF0);
    chk("b_gpio", b_out & 8'hF0, 8'hA0);
    acc(1'b1, `PORT_B_PULLUP_CONTROL_IDX, 8'hFF);
    acc(1'b1, `PORT_C_PULLUP_CONTROL_IDX, 8'h3C);
    rd("b_pull", `PORT_B_PULLUP_CONTROL_IDX, 8'hFF);
    chk("b_pu", b_pu, 8'h0F);
    chk("c_pu", c_pu, 8'h30);
    en <= 8'hF0;
    tick(6);
    rd("b_pulled", `PORT_B_PIN_STATE_IDX, 8'hAF);
    en <= 8'hFF;
    tick(6);
    sw <= 1'b1;
    ext_b <= 8'h00;
    tick(6);
    rd("b_frozen", `PORT_B_PIN_STATE_IDX, 8'hAA);
    chk("b_pu_sb", b_pu, 8'h0F);
    sw <= 1'b0;
    ext_b <= 8'h5A;
    mode <= 3'h6;
    tick(6);
    chk("b_addr", b_out & 8'hF0, 8'h10);
    chk("c_addr", c_out & 8'h0F, 8'h04);
    chk("c_oe6", c_oe, 8'h0F);
    for (int m = 4; m < 6; m++) begin
      mode <= m[2:0];
      tick(6);
      chk("b_oe45", b_oe & c_oe, 8'hFF);
      chk("b_a45", b_out, 8'h12);
      chk("c_a45", c_out, 8'h34);
      chk("pu45", b_pu | c_pu, 8'h00);
    end
    sw <= 1'b1;
    tick(6);
    chk("sb_float", b_oe, 8'h00);
    keep <= 1'b1;
    addr <= 16'hABCD;
    tick(6);
    chk("sb_keep", c_oe, 8'hFF);
    chk("sb_addr", c_out, 8'h34);
    sw <= 1'b0;
    keep <= 1'b0;
    hw <= 1'b1;
    tick(8);
    chk("hw_oe", c_oe, 8'h00);
    hw <= 1'b0;
    mode <= 3'h7;
    tick(6);
    rd("b_data", `PORT_B_OUTPUT_DATA_IDX, 8'h00);
    rd("c_pull", `PORT_C_PULLUP_CONTROL_IDX, 8'h00);
    chk("b_oe_clr", b_oe, 8'h00);
    rd("b_state", `PORT_B_PIN_STATE_IDX, 8'h5A);
    acc(1'b1, `PORT_B_OUTPUT_DATA_IDX, 8'h3C);
    rst_b_in <= 1'b0;
    tick(2);
    rst_b_in <= 1'b1;
    tick(4);
    rd("b_data_rst", `PORT_B_OUTPUT_DATA_IDX, 8'h00);
    rd("b_state_rst", `PORT_B_PIN_STATE_IDX, 8'h5A);
    rd("unmapped", 16'hFF70, 8'h00);
    results;
  end
endmodule
`default_nettype wire
